/* verilog/slrb_pkg.sv */
// Shared constants and types of the log record builder.
package slrb_pkg;
	// Log address that selects the self-test sector.
	localparam logic [7:0] SLRB_LOG_SELFTEST = 8'h06;
	// Revision word of the self-test sector, low byte first.
	localparam logic [7:0] SLRB_REV_LO = 8'h01;
	localparam logic [7:0] SLRB_REV_HI = 8'h00;
	// Descriptor ring geometry.
	localparam int SLRB_NUM_DESC = 21;
	localparam int SLRB_DESC_BYTES = 24;
	// Stored width of one descriptor: bytes n to n+8.
	localparam int SLRB_DESC_BITS = 72;
	// Byte positions inside the 512-byte sector.
	localparam logic [8:0] SLRB_POS_REV_HI = 9'h001;
	localparam logic [8:0] SLRB_POS_DESC_LO = 9'h002;
	localparam logic [8:0] SLRB_POS_DESC_HI = 9'h1F9;
	localparam logic [8:0] SLRB_POS_INDEX = 9'h1FC;
	localparam logic [8:0] SLRB_POS_CSUM = 9'h1FF;
	// Last byte offset inside a descriptor and last ring slot.
	localparam logic [4:0] SLRB_OFF_LAST = 5'h17;
	localparam logic [4:0] SLRB_SLOT_LAST = 5'h14;
	// Index value of a full ring.
	localparam logic [7:0] SLRB_INDEX_FULL = 8'h15;
	// Byte positions inside the error data structure.
	localparam logic [4:0] SLRB_ERR_RSVD = 5'h00;
	localparam logic [4:0] SLRB_ERR_ERROR = 5'h01;
	localparam logic [4:0] SLRB_ERR_SECCNT = 5'h02;
	localparam logic [4:0] SLRB_ERR_SECNUM = 5'h03;
	localparam logic [4:0] SLRB_ERR_CYLLO = 5'h04;
	localparam logic [4:0] SLRB_ERR_CYLHI = 5'h05;
	localparam logic [4:0] SLRB_ERR_DEVHEAD = 5'h06;
	localparam logic [4:0] SLRB_ERR_STATUS = 5'h07;
	localparam logic [4:0] SLRB_ERR_UNUSED = 5'h1A;
	localparam logic [4:0] SLRB_ERR_STATE = 5'h1B;
	localparam logic [4:0] SLRB_ERR_HRS_LO = 5'h1C;
	localparam logic [4:0] SLRB_ERR_HRS_HI = 5'h1D;
	// Device power state codes kept in the error data structure.
	typedef enum logic [7:0] {
		SLRB_PWR_SLEEP   = 8'h01,
		SLRB_PWR_STANDBY = 8'h02,
		SLRB_PWR_ACTIVE  = 8'h03,
		SLRB_PWR_TEST    = 8'h04
	} slrb_power_e;
endpackage : slrb_pkg

/* verilog/slrb_desc_mem.sv */
// Descriptor storage with one write port and a registered read port.
`timescale 1ns/100ps
module slrb_desc_mem #(
	parameter int DEPTH = 21,
	parameter int WIDTH = 72,
	parameter int AW    = 5
) (
	input  wire logic             clk_sys,
	input  wire logic             wrEn,
	input  wire logic [AW-1:0]    wrAddr,
	input  wire logic [WIDTH-1:0] wrData,
	input  wire logic [AW-1:0]    rdAddr,
	output logic      [WIDTH-1:0] rdQ
);
	// The array has no reset; the owner masks slots never written.
	logic [WIDTH-1:0] store [DEPTH];

	// Refuse an address width that cannot reach every slot.
	initial begin
		if ((1 << AW) < DEPTH) begin
			$error("slrb_desc_mem: AW too small for DEPTH");
		end
	end

	// Write port.
	always_ff @(posedge clk_sys) begin
		if (wrEn) begin
			store[wrAddr] <= wrData;
		end
	end

	// Read data comes out of a register, one cycle after the address.
	always_ff @(posedge clk_sys) begin
		rdQ <= store[rdAddr];
	end
endmodule : slrb_desc_mem

/* verilog/slrb_builder.sv */
// Builder of the error data structure and the self-test log sector.
`timescale 1ns/100ps
module slrb_builder (
	input  wire logic                 clk_sys,
	input  wire logic                 nrst,
	input  wire logic                 cmdWrite,
	input  wire slrb_pkg::slrb_power_e powerState,
	input  wire logic                 errDone,
	input  wire logic [7:0]           tfError,
	input  wire logic [7:0]           tfSecCount,
	input  wire logic [7:0]           tfSecNum,
	input  wire logic [7:0]           tfCylLo,
	input  wire logic [7:0]           tfCylHi,
	input  wire logic [7:0]           tfDevHead,
	input  wire logic [7:0]           tfStatus,
	input  wire logic [15:0]          powerOnHours,
	input  wire logic                 stIssue,
	input  wire logic                 stDone,
	input  wire logic [7:0]           stExecStatus,
	input  wire logic [7:0]           stCheckpoint,
	input  wire logic [31:0]          stFailLba,
	input  wire logic [4:0]           errRdAddr,
	output logic      [7:0]           errRdData,
	input  wire logic                 rdStart,
	input  wire logic [7:0]           rdLogAddr,
	output logic                      rdReject,
	output logic                      rdBusy,
	output logic                      rdValid,
	input  wire logic                 rdReady,
	output logic      [7:0]           rdData,
	output logic                      rdLast,
	output logic      [7:0]           stIndex
);
	import slrb_pkg::*;

	// Sector read sequencer states.
	typedef enum logic [1:0] {
		SLRB_IDLE  = 2'b00,
		SLRB_SEND  = 2'b01,
		SLRB_FETCH = 2'b10,
		SLRB_DRAIN = 2'b11
	} slrb_seq_e;

	slrb_power_e stateAtCmd_reg;   // Power state when the command arrived.
	logic [7:0]  capErr_reg;       // Error register snapshot.
	logic [7:0]  capSecCnt_reg;    // Sector count snapshot.
	logic [7:0]  capSecNum_reg;    // Sector number snapshot.
	logic [7:0]  capCylLo_reg;     // Cylinder low snapshot.
	logic [7:0]  capCylHi_reg;     // Cylinder high snapshot.
	logic [7:0]  capDevHead_reg;   // Device/head snapshot.
	logic [7:0]  capStatus_reg;    // Status snapshot.
	logic [15:0] capHours_reg;     // Power-on hours snapshot.
	logic [7:0]  stSecNum_reg;     // Sector number given with the subcommand.
	logic [7:0]  index_reg;        // Most recent descriptor, zero if empty.
	logic [20:0] slotUsed_reg;     // One bit per ring slot ever written.
	logic [4:0]  wrSlot;           // Slot that the next result fills.
	logic [SLRB_DESC_BITS-1:0] descWord; // Stored part of a descriptor.
	logic [SLRB_DESC_BITS-1:0] memQ;     // Descriptor being streamed.
	slrb_seq_e   seq_reg;          // Sequencer state.
	logic [8:0]  pos_reg;          // Sector byte to be loaded next.
	logic [4:0]  entry_reg;        // Descriptor being streamed.
	logic [4:0]  off_reg;          // Byte offset inside that descriptor.
	logic [7:0]  sum_reg;          // Sum of the bytes loaded so far.
	logic [7:0]  curByte;          // Byte at pos_reg.
	logic        inDesc;           // pos_reg lies inside the descriptors.
	logic        load;             // Output register takes curByte.
	logic        accept;           // A read request is taken.

	// Snapshot the power state on each command write.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stateAtCmd_reg <= SLRB_PWR_ACTIVE;
		end else if (cmdWrite) begin
			stateAtCmd_reg <= powerState;
		end
	end

	// Capture the task file and hours when a failing command completes.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			capErr_reg     <= 8'h00;
			capSecCnt_reg  <= 8'h00;
			capSecNum_reg  <= 8'h00;
			capCylLo_reg   <= 8'h00;
			capCylHi_reg   <= 8'h00;
			capDevHead_reg <= 8'h00;
			capStatus_reg  <= 8'h00;
			capHours_reg   <= 16'h0000;
		end else if (errDone) begin
			capErr_reg     <= tfError;
			capSecCnt_reg  <= tfSecCount;
			capSecNum_reg  <= tfSecNum;
			capCylLo_reg   <= tfCylLo;
			capCylHi_reg   <= tfCylHi;
			capDevHead_reg <= tfDevHead;
			capStatus_reg  <= tfStatus;
			capHours_reg   <= powerOnHours;
		end
	end

	// Error data structure read port; data appear one cycle later.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			errRdData <= 8'h00;
		end else if (errRdAddr == SLRB_ERR_ERROR) begin
			errRdData <= capErr_reg;
		end else if (errRdAddr == SLRB_ERR_SECCNT) begin
			errRdData <= capSecCnt_reg;
		end else if (errRdAddr == SLRB_ERR_SECNUM) begin
			errRdData <= capSecNum_reg;
		end else if (errRdAddr == SLRB_ERR_CYLLO) begin
			errRdData <= capCylLo_reg;
		end else if (errRdAddr == SLRB_ERR_CYLHI) begin
			errRdData <= capCylHi_reg;
		end else if (errRdAddr == SLRB_ERR_DEVHEAD) begin
			errRdData <= capDevHead_reg;
		end else if (errRdAddr == SLRB_ERR_STATUS) begin
			errRdData <= capStatus_reg;
		end else if (errRdAddr == SLRB_ERR_STATE) begin
			errRdData <= stateAtCmd_reg;
		end else if (errRdAddr == SLRB_ERR_HRS_LO) begin
			errRdData <= capHours_reg[7:0];
		end else if (errRdAddr == SLRB_ERR_HRS_HI) begin
			errRdData <= capHours_reg[15:8];
		end else begin
			// Reserved, vendor and unassigned bytes stay zero.
			errRdData <= 8'h00;
		end
	end

	// Keep the sector number that came with the self-test subcommand.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stSecNum_reg <= 8'h00;
		end else if (stIssue) begin
			stSecNum_reg <= tfSecNum;
		end
	end

	// The index doubles as the write pointer: a full ring writes slot 0.
	assign wrSlot = (index_reg == SLRB_INDEX_FULL) ? 5'h00 : index_reg[4:0];
	// Descriptor bytes n to n+8, low byte at the low address of a field.
	assign descWord = {stFailLba, stCheckpoint, powerOnHours, stExecStatus,
		stSecNum_reg};

	// Index and slot bookkeeping on each finished self-test.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			index_reg    <= 8'h00;
			slotUsed_reg <= 21'h000000;
		end else if (stDone) begin
			index_reg <= {3'h0, wrSlot} + 8'h01;
			slotUsed_reg[wrSlot] <= 1'b1;
		end
	end
	assign stIndex = index_reg;

	// Ring storage; the read address follows the streamed descriptor.
	slrb_desc_mem #(
		.DEPTH (SLRB_NUM_DESC),
		.WIDTH (SLRB_DESC_BITS),
		.AW    (5)
	) u_mem (
		.clk_sys (clk_sys),
		.wrEn    (stDone),
		.wrAddr  (wrSlot),
		.wrData  (descWord),
		.rdAddr  (entry_reg),
		.rdQ     (memQ)
	);

	// Sector byte selection by position.
	assign inDesc = (pos_reg >= SLRB_POS_DESC_LO) &&
		(pos_reg <= SLRB_POS_DESC_HI);
	always_comb begin
		curByte = 8'h00;
		if (pos_reg == 9'h000) begin
			curByte = SLRB_REV_LO;
		end else if (pos_reg == SLRB_POS_REV_HI) begin
			curByte = SLRB_REV_HI;
		end else if (inDesc) begin
			// Slots never written, and vendor bytes, read as zero.
			if (slotUsed_reg[entry_reg] && off_reg < 5'h09) begin
				curByte = memQ[off_reg*8 +: 8];
			end
		end else if (pos_reg == SLRB_POS_INDEX) begin
			curByte = index_reg;
		end else if (pos_reg == SLRB_POS_CSUM) begin
			curByte = 8'h00 - sum_reg;
		end
	end

	// Only the self-test sector is served; the rest is refused.
	assign accept = rdStart && (seq_reg == SLRB_IDLE) &&
		(rdLogAddr == SLRB_LOG_SELFTEST);
	assign rdReject = rdStart && !accept;
	assign rdBusy = (seq_reg != SLRB_IDLE);
	assign load = (seq_reg == SLRB_SEND) && (!rdValid || rdReady);

	// Sequencer; a fetch cycle lets the memory catch up at each entry.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			seq_reg   <= SLRB_IDLE;
			pos_reg   <= 9'h000;
			entry_reg <= 5'h00;
			off_reg   <= 5'h00;
			sum_reg   <= 8'h00;
		end else begin
			case (seq_reg)
				SLRB_IDLE: begin
					if (accept) begin
						seq_reg   <= SLRB_SEND;
						pos_reg   <= 9'h000;
						entry_reg <= 5'h00;
						off_reg   <= 5'h00;
						sum_reg   <= 8'h00;
					end
				end
				SLRB_SEND: begin
					if (load) begin
						pos_reg <= pos_reg + 9'h001;
						sum_reg <= sum_reg + curByte;
						if (pos_reg == SLRB_POS_CSUM) begin
							seq_reg <= SLRB_DRAIN;
						end else if (pos_reg == SLRB_POS_REV_HI) begin
							seq_reg <= SLRB_FETCH;
						end else if (inDesc && off_reg == SLRB_OFF_LAST) begin
							off_reg <= 5'h00;
							if (entry_reg != SLRB_SLOT_LAST) begin
								entry_reg <= entry_reg + 5'h01;
								seq_reg   <= SLRB_FETCH;
							end
						end else if (inDesc) begin
							off_reg <= off_reg + 5'h01;
						end
					end
				end
				SLRB_FETCH: begin
					seq_reg <= SLRB_SEND;
				end
				default: begin
					if (rdReady) begin
						seq_reg <= SLRB_IDLE;
					end
				end
			endcase
		end
	end

	// Output register; it holds until the host takes the byte.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdValid <= 1'b0;
			rdData  <= 8'h00;
			rdLast  <= 1'b0;
		end else if (load) begin
			rdValid <= 1'b1;
			rdData  <= curByte;
			rdLast  <= (pos_reg == SLRB_POS_CSUM);
		end else if (rdReady) begin
			rdValid <= 1'b0;
			rdLast  <= 1'b0;
		end
	end

	// Helper for the checks: position and sum of bytes the host took.
	logic [8:0] outPos;
	logic [7:0] outSum;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			outPos <= 9'h000;
			outSum <= 8'h00;
		end else if (accept) begin
			outPos <= 9'h000;
			outSum <= 8'h00;
		end else if (rdValid && rdReady) begin
			outPos <= outPos + 9'h001;
			outSum <= outSum + rdData;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	property p_rsvd; errRdAddr == SLRB_ERR_RSVD |=> errRdData == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved byte set");
	property p_status;
		errDone ##1 (errRdAddr == SLRB_ERR_STATUS && !errDone)
			|=> errRdData == $past(tfStatus, 2);
	endproperty
	a_status: assert property (p_status) else $error("bad status");
	property p_state;
		cmdWrite ##1 (!cmdWrite && errRdAddr == SLRB_ERR_STATE)
			|=> errRdData == $past(powerState, 2);
	endproperty
	a_state: assert property (p_state) else $error("bad state");
	property p_unused; errRdAddr == SLRB_ERR_UNUSED |=> errRdData == 8'h00;
	endproperty
	a_unused: assert property (p_unused) else $error("byte 26 set");
	property p_rev;
		rdValid && outPos == 9'h000 |-> rdData == SLRB_REV_LO;
	endproperty
	a_rev: assert property (p_rev) else $error("bad revision");
	property p_wrap;
		stDone && index_reg == SLRB_INDEX_FULL |=> index_reg == 8'h01;
	endproperty
	a_wrap: assert property (p_wrap) else $error("index no wrap");
	property p_step;
		stDone && index_reg < SLRB_INDEX_FULL
			|=> index_reg == $past(index_reg) + 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("index no step");
	property p_csum;
		rdValid && rdLast |-> outSum + rdData == 8'h00;
	endproperty
	a_csum: assert property (p_csum) else $error("bad checksum");
	property p_last;
		rdValid && rdLast |-> outPos == SLRB_POS_CSUM;
	endproperty
	a_last: assert property (p_last) else $error("bad length");
endmodule : slrb_builder

/* testbench/slrb_host_model.sv */
// Host model that fetches log sectors over the streaming read port.
`timescale 1ns/100ps
module slrb_host_model (
	input  wire logic       clk_sys,
	output logic            rdStart,
	output logic      [7:0] rdLogAddr,
	input  wire logic       rdReject,
	input  wire logic       rdValid,
	output logic            rdReady,
	input  wire logic [7:0] rdData,
	input  wire logic       rdLast
);
	// Bytes gathered by the last fetch and what the port reported.
	logic [7:0] sector [512];
	int         nBytes;
	int         lastAt;
	logic       rejFirst;
	logic       rejDup;

	// The host starts idle with nothing requested.
	initial begin
		rdStart   = 1'b0;
		rdLogAddr = 8'h00;
		rdReady   = 1'b0;
	end

	// Requests one sector; a stall above zero drops ready on every stall-th cycle.
	// Dup keeps the request up a second cycle, which the port must refuse.
	task automatic fetch(input logic [7:0] addr, input int stall,
			input bit dup);
		int cyc;
		nBytes = 0;
		lastAt = -1;
		rejDup = 1'b0;
		@(negedge clk_sys);
		rdStart   = 1'b1;
		rdLogAddr = addr;
		#1 rejFirst = rdReject;
		if (dup) begin
			@(negedge clk_sys);
			#1 rejDup = rdReject;
		end
		@(negedge clk_sys);
		rdStart   = 1'b0;
		// A released address shows its inverse so stale use is caught.
		rdLogAddr = ~addr;
		// A byte offered while ready is set here is taken at the next edge.
		for (cyc = 0; !rejFirst && cyc < 2000 && nBytes < 512; cyc++) begin
			rdReady = (stall == 0) || (cyc % stall != 0);
			if (rdValid && rdReady) begin
				sector[nBytes] = rdData;
				if (rdLast) lastAt = nBytes;
				nBytes++;
			end
			@(negedge clk_sys);
		end
		rdReady = 1'b0;
	endtask : fetch
endmodule : slrb_host_model

/* testbench/slrb_builder_tb.sv */
// Self-checking bench of the log record builder.
`timescale 1ns/100ps
module slrb_builder_tb;
	import slrb_pkg::*;
	logic        clk_sys, nrst, cmdWrite, errDone, stIssue, stDone;
	slrb_power_e powerState;
	logic [7:0]  tf [7];
	logic [15:0] powerOnHours;
	logic [7:0]  stExecStatus, stCheckpoint, errRdData, rdLogAddr;
	logic [31:0] stFailLba;
	logic [4:0]  errRdAddr;
	logic        rdStart, rdReject, rdBusy, rdValid, rdReady, rdLast;
	logic [7:0]  rdData, stIndex;
	// Expected descriptor ring, kept from the stimulus alone.
	logic [7:0]  dSec [21];
	logic [7:0]  dExec [21];
	logic [7:0]  dChk [21];
	logic [15:0] dHrs [21];
	logic [31:0] dLba [21];
	logic [7:0]  idx;
	int          nTests;
	int          errCount;
	int          checked;

	slrb_builder i_slrb_builder (.clk_sys(clk_sys), .nrst(nrst),
		.cmdWrite(cmdWrite), .powerState(powerState), .errDone(errDone),
		.tfError(tf[0]), .tfSecCount(tf[1]), .tfSecNum(tf[2]),
		.tfCylLo(tf[3]), .tfCylHi(tf[4]), .tfDevHead(tf[5]),
		.tfStatus(tf[6]), .powerOnHours(powerOnHours), .stIssue(stIssue),
		.stDone(stDone), .stExecStatus(stExecStatus),
		.stCheckpoint(stCheckpoint), .stFailLba(stFailLba),
		.errRdAddr(errRdAddr), .errRdData(errRdData), .rdStart(rdStart),
		.rdLogAddr(rdLogAddr), .rdReject(rdReject), .rdBusy(rdBusy),
		.rdValid(rdValid), .rdReady(rdReady), .rdData(rdData),
		.rdLast(rdLast), .stIndex(stIndex));

	slrb_host_model i_slrb_host_model (.clk_sys(clk_sys),
		.rdStart(rdStart), .rdLogAddr(rdLogAddr), .rdReject(rdReject),
		.rdValid(rdValid), .rdReady(rdReady), .rdData(rdData),
		.rdLast(rdLast));

	// Compares one value and reports a mismatch at once.
	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			errCount++;
			$display("wrong value %s expected %0h seen %0h", what, want, seen);
		end
	endtask : check

	// Prints the verdict and ends the run.
	task automatic complete_run;
		if (errCount == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	// Reads one byte of the error structure; the answer lags one edge.
	task automatic err_read(input int a, output logic [7:0] d);
		@(negedge clk_sys);
		errRdAddr = 5'(a);
		@(negedge clk_sys);
		d = errRdData;
	endtask : err_read

	// Builds the expected sector, fetches it and compares every byte.
	task automatic check_sector(input int stall, input bit dup);
		logic [7:0] img [512];
		logic [7:0] sum;
		int         b;
		int         k;
		for (b = 0; b < 512; b++) img[b] = 8'h00;
		img[0] = SLRB_REV_LO;
		img[1] = SLRB_REV_HI;
		for (k = 0; k < 21 && k < nTests; k++) begin
			b = 2 + 24 * k;
			img[b]     = dSec[k];
			img[b + 1] = dExec[k];
			img[b + 2] = dHrs[k][7:0];
			img[b + 3] = dHrs[k][15:8];
			img[b + 4] = dChk[k];
			img[b + 5] = dLba[k][7:0];
			img[b + 6] = dLba[k][15:8];
			img[b + 7] = dLba[k][23:16];
			img[b + 8] = dLba[k][31:24];
		end
		img[508] = idx;
		sum = 8'h00;
		for (b = 0; b < 511; b++) sum = sum + img[b];
		img[511] = 8'h00 - sum;
		i_slrb_host_model.fetch(SLRB_LOG_SELFTEST, stall, dup);
		check("accept", i_slrb_host_model.rejFirst, 0);
		if (dup) check("busy refuse", i_slrb_host_model.rejDup, 1);
		check("byte count", i_slrb_host_model.nBytes, 512);
		check("last position", i_slrb_host_model.lastAt, 511);
		for (b = 0; b < 512; b++)
			check("sector byte", i_slrb_host_model.sector[b], img[b]);
		repeat (2) @(negedge clk_sys);
		check("idle after read", rdBusy, 0);
	endtask : check_sector

	// After reset the ring is empty and the state code is active.
	task automatic test_reset;
		logic [7:0] d;
		check("empty index", stIndex, 0);
		err_read(27, d);
		check("reset state", d, SLRB_PWR_ACTIVE);
		check_sector(0, 0);
	endtask : test_reset

	// Each power code is latched at the command write, the rest at done.
	task automatic test_error;
		logic [7:0] d;
		logic [7:0] e;
		int         c;
		int         a;
		for (c = 1; c <= 4; c++) begin
			@(negedge clk_sys);
			powerState = slrb_power_e'(8'(c));
			cmdWrite   = 1'b1;
			@(negedge clk_sys);
			cmdWrite   = 1'b0;
			// Point the read port at the state byte, so that the state check runs.
			errRdAddr  = SLRB_ERR_STATE;
			// Moving the state after the write must not change the record.
			powerState = slrb_power_e'(8'(c % 4 + 1));
			for (a = 0; a < 7; a++) tf[a] = 8'(c * 16 + a + 1);
			powerOnHours = 16'hBE00 + 16'(c);
			errDone = 1'b1;
			@(negedge clk_sys);
			errDone = 1'b0;
			// The status check needs the status byte addressed right after done.
			errRdAddr = SLRB_ERR_STATUS;
			for (a = 0; a < 7; a++) tf[a] = ~tf[a];
			powerOnHours = 16'h0000;
			for (a = 0; a < 30; a++) begin
				e = (a >= 1 && a <= 7) ? 8'(c * 16 + a) :
					(a == 27 || a == 28) ? 8'(c) : (a == 29) ? 8'hBE : 8'h00;
				err_read(a, d);
				check("error byte", d, e);
			end
		end
	endtask : test_error

	// Runs self-test number n and follows the index.
	task automatic st_run(input int n);
		int slot;
		slot = (n - 1) % 21;
		@(negedge clk_sys);
		tf[2]   = 8'(n) + 8'h30;
		stIssue = 1'b1;
		@(negedge clk_sys);
		stIssue = 1'b0;
		tf[2]   = ~tf[2];
		stExecStatus = 8'(n) + 8'h10;
		stCheckpoint = 8'(n) + 8'h50;
		stFailLba    = {8'(n) + 8'hC0, 8'h11, 8'(n), 8'h7E};
		powerOnHours = 16'h0300 + 16'(n);
		stDone = 1'b1;
		@(negedge clk_sys);
		stDone = 1'b0;
		dSec[slot]  = 8'(n) + 8'h30;
		dExec[slot] = stExecStatus;
		dChk[slot]  = stCheckpoint;
		dHrs[slot]  = powerOnHours;
		dLba[slot]  = stFailLba;
		idx = 8'(slot + 1);
		nTests++;
		check("index", stIndex, idx);
	endtask : st_run

	// A reset in mid-run must empty the ring although stale words stay stored.
	task automatic test_midreset;
		@(negedge clk_sys);
		nrst = 1'b0;
		repeat (2) @(negedge clk_sys);
		nrst   = 1'b1;
		idx    = 8'h00;
		nTests = 0;
		test_reset;
	endtask : test_midreset

	// A request for another log address is refused and starts nothing.
	task automatic test_reject;
		i_slrb_host_model.fetch(8'h01, 0, 0);
		check("refuse address", i_slrb_host_model.rejFirst, 1);
		check("no stream", rdValid, 0);
		check("stays idle", rdBusy, 0);
	endtask : test_reject

	// Free-running system clock.
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// Main sequence: reset, error capture, refusals, then the ring.
	initial begin
		int n;
		nrst = 1'b0;
		{cmdWrite, errDone, stIssue, stDone} = 4'h0;
		powerState = SLRB_PWR_ACTIVE;
		for (n = 0; n < 7; n++) tf[n] = 8'h00;
		{powerOnHours, stExecStatus, stCheckpoint} = 32'h0;
		stFailLba = 32'h0;
		errRdAddr = 5'h00;
		idx = 8'h00;
		repeat (5) @(negedge clk_sys);
		nrst = 1'b1;
		test_reset;
		test_error;
		test_reject;
		for (n = 1; n <= 5; n++) st_run(n);
		check_sector(0, 1);
		for (n = 6; n <= 21; n++) st_run(n);
		check_sector(3, 0);
		// The 22nd and 23rd results overwrite entries one and two.
		for (n = 22; n <= 23; n++) st_run(n);
		check_sector(2, 0);
		test_midreset;
		complete_run;
	end

	// Cuts a hang short after about 50000 cycles.
	initial begin
		#400000;
		errCount++;
		complete_run;
	end
endmodule : slrb_builder_tb
